// [hsc_pkg.sv]
// Package for the host special-cycle and SMM steering block.
// Assumes a single 100 MHz system bus clock and Avalon-MM register access.
package hsc_pkg;
  localparam logic [7:0] SC_NOP = 8'h00;
  localparam logic [7:0] SC_SHUTDOWN = 8'h01;
  localparam logic [7:0] SC_FLUSH = 8'h02;
  localparam logic [7:0] SC_HALT = 8'h03;
  localparam logic [7:0] SC_SYNC = 8'h04;
  localparam logic [7:0] SC_FLUSH_ACK = 8'h05;
  localparam logic [7:0] SC_STOPCLK_ACK = 8'h06;
  localparam logic [7:0] SC_SMI_ACK = 8'h07;
  localparam logic [1:0] TP_ACCEPT = 2'h0;
  localparam logic [1:0] TP_HARDFAIL = 2'h1;
  localparam logic [1:0] TP_RETRY = 2'h2;
  localparam logic [1:0] TP_DEFER = 2'h3;
  // Response codes on the resp bus
  localparam logic [1:0] RESP_NORMAL = 2'h0;
  localparam logic [1:0] RESP_RETRY = 2'h1;
  localparam logic [1:0] RESP_DEFER = 2'h2;
  // Forwarded PCI special cycle kinds
  localparam logic [1:0] PCI_SC_HALT = 2'h1;
  localparam logic [1:0] PCI_SC_STOPGRANT = 2'h2;
  // Init pulse timing
  localparam int CLK_MHZ = 100;
  localparam int INIT_MIN_CLOCKS = 4;
  localparam logic [3:0] INIT_CYCLES = 4'(INIT_MIN_CLOCKS);
  // Register map, byte addresses
  localparam logic [3:0] REG_SMM_CTRL = 4'h0;
  localparam logic [3:0] REG_SMM_BASE = 4'h4;
  localparam logic [3:0] REG_SMM_SIZE = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  // Control field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_OPEN = 1;
  localparam int CTRL_CODE = 2;
  localparam int CTRL_LOCK = 3;
  // Window in 64 KB units; base A000h in a 16-bit segment view is address A0000h -> unit 0ah
  localparam logic [19:0] SMM_BASE_RST = 20'h0000a;
  localparam logic [7:0] SMM_SIZE_RST = 8'h01;
  localparam logic [31:0] BAD_ADDR_DATA = 32'hdeadbeef;

  typedef enum logic [2:0] {TK_NONE, TK_BRTRACE, TK_SPECIAL, TK_MEM, TK_OTHER} hsc_kind_t;

  // Request seen by the host bus request phase logic
  typedef struct packed {
    logic valid;
    hsc_kind_t kind;
    logic [35:3] first_phase_address;
    logic [15:8] second_phase_type_bits;
    logic smm_request_flag;
    logic code_fetch;
  } hsc_req_t;

  // Response handed back to the host bus
  typedef struct packed {
    logic valid;
    logic [1:0] code;
  } hsc_resp_t;

  typedef struct packed {
    logic smm_space_enable;
    logic open;
    logic code_only;
    logic smm_window_lock;
  } hsc_smm_ctl_t;
endpackage : hsc_pkg

// [hsc_smm_route.sv]
// SMM window steering decode.
// Assumes the address is a host physical address and the controls are stable registers.
`timescale 1ns/1ps
module hsc_smm_route (
  input wire hsc_pkg::hsc_smm_ctl_t ctl,
  input wire logic [19:0] base_64k,
  input wire logic [7:0] size_64k,
  input wire logic [35:3] addr,
  input wire logic smm_request_flag,
  input wire logic code_fetch,
  output logic in_window,
  output logic steer_valid,
  output logic to_dram
);
  wire [35:16] unit = addr[35:16];
  wire [20:0] top = {1'b0, base_64k} + {13'h0000, size_64k};
  // Lock removes the open override, so a locked window cannot be reopened
  wire open_eff = ctl.open & ~ctl.smm_window_lock;
  wire closed_dram = ctl.code_only ? (smm_request_flag & code_fetch) : smm_request_flag;

  // Window grows from the base in whole 64 KB units
  assign in_window = ({1'b0, unit} >= {1'b0, base_64k}) && ({1'b0, unit} < top);
  // Steering only applies with the master enable set
  assign steer_valid = ctl.smm_space_enable & in_window;
  assign to_dram = open_eff ? 1'b1 : closed_dram;
endmodule : hsc_smm_route

// [hsc_special_cycle.sv]
// Host bus special cycle, SMM and third-party response logic.
// Assumes decoded host requests, snoop phase timing from the bus tracker, and a compat PCI forwarder.
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module hsc_special_cycle (
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Host request phase
  input wire hsc_pkg::hsc_req_t req,
  // Snoop phase last cycle and the third-party code pin
  input wire logic snoop_last,
  input wire logic [1:0] intervention_code,
  // Host response
  output hsc_pkg::hsc_resp_t resp,
  output logic init_out_n,
  output logic smm_active_out,
  // SMM steering result
  output logic smm_steer_valid,
  output logic smm_to_dram,
  // Compat PCI bus 0A special cycle forwarder
  output logic compat_pci_req,
  output logic [1:0] compat_pci_kind,
  input wire logic compat_pci_master_abort,
  input wire logic compat_pci_ready
);
  typedef enum logic [1:0] {ST_IDLE, ST_PCI_REQ, ST_PCI_WAIT} hsc_state_t;

  hsc_state_t state_r;
  hsc_state_t state_nxt;
  logic rst_s1_r;
  logic rst_s2_r;
  logic [1:0] tp_s1_r;
  logic [1:0] tp_s2_r;
  logic abort_s1_r;
  logic abort_s2_r;
  logic rdy_s1_r;
  logic rdy_s2_r;
  hsc_pkg::hsc_smm_ctl_t ctl_r;
  logic [19:0] base_r;
  logic [7:0] size_r;
  logic smm_act_r;
  logic [3:0] init_cnt_r;
  logic [1:0] pci_kind_r;
  hsc_pkg::hsc_resp_t resp_r;
  hsc_pkg::hsc_resp_t resp_nxt;
  logic [31:0] rdata_r;
  logic [1:0] pending_kind_r;
  logic retire_now;
  logic in_window;

  // Release reset through two flops so all logic leaves reset together
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  wire rst_in_n = rst_s2_r;

  // Pin inputs from outside agents pass two flops before use
  always_ff @(posedge sys_clk or negedge rst_in_n)
  begin
    if (!rst_in_n)
    begin
      tp_s1_r <= 2'h0;
      tp_s2_r <= 2'h0;
      abort_s1_r <= 1'b0;
      abort_s2_r <= 1'b0;
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
    end
    else
    begin
      tp_s1_r <= intervention_code;
      tp_s2_r <= tp_s1_r;
      abort_s1_r <= compat_pci_master_abort;
      abort_s2_r <= abort_s1_r;
      rdy_s1_r <= compat_pci_ready;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  // Special cycle type decode uses only the second phase bits
  wire is_special = req.valid && (req.kind == hsc_pkg::TK_SPECIAL);
  wire [7:0] sc_type = req.second_phase_type_bits;
  wire sc_nop = is_special && (sc_type == hsc_pkg::SC_NOP);
  wire sc_shutdown = is_special && (sc_type == hsc_pkg::SC_SHUTDOWN);
  wire sc_halt = is_special && (sc_type == hsc_pkg::SC_HALT);
  wire sc_stopclk = is_special && (sc_type == hsc_pkg::SC_STOPCLK_ACK);
  wire sc_smi_ack = is_special && (sc_type == hsc_pkg::SC_SMI_ACK);
  wire sc_retire_only = is_special && ((sc_type == hsc_pkg::SC_FLUSH) || (sc_type == hsc_pkg::SC_SYNC)
                        || (sc_type == hsc_pkg::SC_FLUSH_ACK));
  // Reserved codes are simply retired so the bus never hangs on them
  wire sc_reserved = is_special && (sc_type > hsc_pkg::SC_SMI_ACK);
  wire brtrace = req.valid && (req.kind == hsc_pkg::TK_BRTRACE);
  wire fwd_pci = (sc_halt || sc_stopclk) && (state_r == ST_IDLE);
  wire immediate = brtrace || sc_nop || sc_shutdown || sc_retire_only || sc_reserved || sc_smi_ack;
  wire tp_sample = snoop_last && req.valid && (req.kind == hsc_pkg::TK_MEM);

  // Forwarded cycle sequence: request PCI, then wait for master abort
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (fwd_pci)
        begin
          state_nxt = ST_PCI_REQ;
        end
      end
      ST_PCI_REQ:
      begin
        if (rdy_s2_r)
        begin
          state_nxt = ST_PCI_WAIT;
        end
      end
      ST_PCI_WAIT:
      begin
        if (abort_s2_r)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  assign retire_now = (state_r == ST_PCI_WAIT) && abort_s2_r;

  // Response selection; the device always drives the answer itself
  always_comb
  begin
    resp_nxt = '0;
    if (tp_sample)
    begin
      resp_nxt.valid = 1'b1;
      case (tp_s2_r)
        hsc_pkg::TP_RETRY: resp_nxt.code = hsc_pkg::RESP_RETRY;
        hsc_pkg::TP_DEFER: resp_nxt.code = hsc_pkg::RESP_DEFER;
        // Hard fail is unsupported and treated as accept
        default: resp_nxt.code = hsc_pkg::RESP_NORMAL;
      endcase
    end
    else if (immediate || retire_now)
    begin
      resp_nxt.valid = 1'b1;
      resp_nxt.code = hsc_pkg::RESP_NORMAL;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_in_n)
  begin
    if (!rst_in_n)
    begin
      state_r <= ST_IDLE;
      resp_r <= '0;
      pending_kind_r <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      resp_r <= resp_nxt;
      if (fwd_pci)
      begin
        pending_kind_r <= sc_halt ? hsc_pkg::PCI_SC_HALT : hsc_pkg::PCI_SC_STOPGRANT;
      end
    end
  end

  // Kind is held stable for the whole forwarded cycle
  always_ff @(posedge sys_clk or negedge rst_in_n)
  begin
    if (!rst_in_n)
    begin
      pci_kind_r <= 2'h0;
    end
    else
    begin
      pci_kind_r <= (state_nxt == ST_IDLE) ? 2'h0 : (fwd_pci ? (sc_halt ? hsc_pkg::PCI_SC_HALT
                    : hsc_pkg::PCI_SC_STOPGRANT) : pending_kind_r);
    end
  end

  // Init pulse: a new shutdown restarts the full count
  always_ff @(posedge sys_clk or negedge rst_in_n)
  begin
    if (!rst_in_n)
    begin
      init_cnt_r <= 4'h0;
    end
    else if (sc_shutdown)
    begin
      init_cnt_r <= hsc_pkg::INIT_CYCLES;
    end
    else if (init_cnt_r != 4'h0)
    begin
      init_cnt_r <= init_cnt_r - 4'h1;
    end
  end

  // SMM active follows the flag seen on each SMI acknowledge
  always_ff @(posedge sys_clk or negedge rst_in_n)
  begin
    if (!rst_in_n)
    begin
      smm_act_r <= 1'b0;
    end
    else if (sc_smi_ack)
    begin
      smm_act_r <= req.smm_request_flag;
    end
  end

  // Register writes; lock freezes the window definition once set
  wire wr_ok = avs_write && !ctl_r.smm_window_lock;
  always_ff @(posedge sys_clk or negedge rst_in_n)
  begin
    if (!rst_in_n)
    begin
      ctl_r <= '0;
      base_r <= hsc_pkg::SMM_BASE_RST;
      size_r <= hsc_pkg::SMM_SIZE_RST;
    end
    else
    begin
      if (avs_write && (avs_address == hsc_pkg::REG_SMM_CTRL))
      begin
        ctl_r.smm_space_enable <= ctl_r.smm_window_lock ? ctl_r.smm_space_enable : avs_writedata[hsc_pkg::CTRL_ENABLE];
        ctl_r.open <= avs_writedata[hsc_pkg::CTRL_OPEN];
        ctl_r.code_only <= ctl_r.smm_window_lock ? ctl_r.code_only : avs_writedata[hsc_pkg::CTRL_CODE];
        // Lock is sticky until reset
        ctl_r.smm_window_lock <= ctl_r.smm_window_lock | avs_writedata[hsc_pkg::CTRL_LOCK];
      end
      if (wr_ok && (avs_address == hsc_pkg::REG_SMM_BASE))
      begin
        base_r <= avs_writedata[19:0];
      end
      if (wr_ok && (avs_address == hsc_pkg::REG_SMM_SIZE))
      begin
        size_r <= (avs_writedata[7:0] == 8'h00) ? hsc_pkg::SMM_SIZE_RST : avs_writedata[7:0];
      end
    end
  end

  // Read mux; unmapped offsets return a marker value
  wire [31:0] rd_mux = (avs_address == hsc_pkg::REG_SMM_CTRL) ? {28'h0000000, ctl_r.smm_window_lock,
                       ctl_r.code_only, ctl_r.open, ctl_r.smm_space_enable}
                     : (avs_address == hsc_pkg::REG_SMM_BASE) ? {12'h000, base_r}
                     : (avs_address == hsc_pkg::REG_SMM_SIZE) ? {24'h000000, size_r}
                     : (avs_address == hsc_pkg::REG_STATUS) ? {27'h0000000, (state_r != ST_IDLE),
                       pending_kind_r, (init_cnt_r != 4'h0), smm_act_r}
                     : hsc_pkg::BAD_ADDR_DATA;

  logic rd_done_r;
  // Reads take one wait cycle so data come from a flop
  always_ff @(posedge sys_clk or negedge rst_in_n)
  begin
    if (!rst_in_n)
    begin
      rd_done_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      rd_done_r <= avs_read && !rd_done_r;
      if (avs_read && !rd_done_r)
      begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign avs_waitrequest = avs_read && !rd_done_r;
  assign avs_readdata = rdata_r;

  hsc_smm_route u_route (
    .ctl(ctl_r),
    .base_64k(base_r),
    .size_64k(size_r),
    .addr(req.first_phase_address),
    .smm_request_flag(req.smm_request_flag),
    .code_fetch(req.code_fetch),
    .in_window(in_window),
    .steer_valid(smm_steer_valid),
    .to_dram(smm_to_dram)
  );

  // Outputs; forwarded special cycles target compat PCI bus 0A only
  assign compat_pci_req = (state_r == ST_PCI_REQ);
  assign compat_pci_kind = pci_kind_r;
  assign resp = resp_r;
  assign init_out_n = (init_cnt_r == 4'h0);
  assign smm_active_out = smm_act_r;
endmodule : hsc_special_cycle

// [hsc_sc_properties.sv]
// Concurrent checks on the host response, init, SMM flag and PCI forwarder ports.
// Assumes a bind onto hsc_special_cycle with one clock domain.
`timescale 1ns/1ps
module hsc_sc_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire hsc_pkg::hsc_req_t req,
  input wire logic snoop_last,
  input wire logic [1:0] intervention_code,
  input wire hsc_pkg::hsc_resp_t resp,
  input wire logic init_out_n,
  input wire logic smm_active_out,
  input wire logic compat_pci_req,
  input wire logic [1:0] compat_pci_kind,
  input wire logic compat_pci_master_abort
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Decoded request strobes and the response the intervention code asks for
  wire logic sc = req.valid && req.kind == hsc_pkg::TK_SPECIAL;
  wire logic [7:0] ty = req.second_phase_type_bits;
  wire logic quick = (req.valid && req.kind == hsc_pkg::TK_BRTRACE) || (sc && ty inside {8'h00, 8'h02, 8'h04, 8'h05});
  wire logic smi = sc && ty == 8'h07;
  wire logic [1:0] tp_exp = intervention_code == 2'h2 ? hsc_pkg::RESP_RETRY :
                            intervention_code == 2'h3 ? hsc_pkg::RESP_DEFER : hsc_pkg::RESP_NORMAL;

  quick_retire_a: assert property (quick |=> resp.valid && resp.code == hsc_pkg::RESP_NORMAL)
    else $error("quick cycle not retired normally");
  init_length_a: assert property ($fell(init_out_n) |-> !init_out_n [*4] ##1 init_out_n)
    else $error("init low time wrong");
  shutdown_init_a: assert property (sc && ty == 8'h01 |=> !init_out_n && !compat_pci_req)
    else $error("shutdown handling wrong");
  smm_track_a: assert property (smi |=> smm_active_out == $past(req.smm_request_flag))
    else $error("smm active not following ack");
  smm_hold_a: assert property (!smi |=> $stable(smm_active_out))
    else $error("smm active changed without ack");
  halt_fwd_a: assert property (sc && ty == 8'h03 && !compat_pci_req |=> compat_pci_req &&
    compat_pci_kind == hsc_pkg::PCI_SC_HALT) else $error("halt not forwarded");
  stop_fwd_a: assert property (sc && ty == 8'h06 && !compat_pci_req |=> compat_pci_req &&
    compat_pci_kind == hsc_pkg::PCI_SC_STOPGRANT) else $error("stop grant not forwarded");
  abort_retire_a: assert property (resp.valid && !$past(req.valid) |->
    $past(compat_pci_master_abort, 2) || $past(compat_pci_master_abort, 3) || $past(compat_pci_master_abort, 4))
    else $error("forwarded cycle retired without abort");
  tp_resp_a: assert property (req.valid && req.kind == hsc_pkg::TK_MEM && snoop_last |=> resp.valid &&
    resp.code == $past(tp_exp)) else $error("intervention response wrong");
endmodule : hsc_sc_properties

bind hsc_special_cycle hsc_sc_properties u_hsc_sc_properties (.sys_clk, .rst_n, .req, .snoop_last,
  .intervention_code, .resp, .init_out_n, .smm_active_out, .compat_pci_req, .compat_pci_kind,
  .compat_pci_master_abort);

// [hsc_pci_partner.sv]
// Behavioural compat PCI side for forwarded halt and stop-grant cycles.
// Assumes no target claims them, so each one ends in master abort.
`timescale 1ns/1ps
module hsc_pci_partner (
  input wire logic sys_clk,
  input wire logic [3:0] dly,
  input wire logic compat_pci_req,
  output logic compat_pci_ready,
  output logic compat_pci_master_abort
);
  int cnt = 0;
  int ab = 0;
  initial
  begin
    compat_pci_ready = 1'b0;
    compat_pci_master_abort = 1'b0;
  end
  // Ready after dly cycles; abort held four cycles so it survives two sync flops
  always @(posedge sys_clk)
  begin
    cnt <= compat_pci_req ? cnt + 1 : 0;
    compat_pci_ready <= compat_pci_req && cnt >= int'(dly);
    ab <= (compat_pci_ready && !compat_pci_req) ? 4 : (ab > 0 ? ab - 1 : 0);
    compat_pci_master_abort <= ab > 0;
  end
endmodule : hsc_pci_partner

// [hsc_special_cycle_bench.sv]
// Self-checking bench for the special-cycle and SMM steering block.
// Assumes the partner model and the bound checker are compiled with it.
`timescale 1ns/1ps
module hsc_special_cycle_bench;
  localparam logic [35:0] WIN = 36'h0000a0100;
  localparam logic [35:0] OUTW = 36'h0000b0100;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  hsc_pkg::hsc_req_t req = '0;
  logic snoop_last = 1'b0;
  logic [1:0] intervention_code = 2'h0;
  hsc_pkg::hsc_resp_t resp;
  logic init_out_n, smm_active_out, smm_steer_valid, smm_to_dram, compat_pci_req;
  logic [1:0] compat_pci_kind;
  logic compat_pci_master_abort, compat_pci_ready;
  logic [3:0] dly = 4'h0;
  logic [35:0] addr = 36'h0;
  logic [31:0] rd;
  logic st_v, st_d, ab_seen;
  logic [1:0] rc, pk;
  int lat;
  int err_count = 0;
  int check_count = 0;

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  hsc_special_cycle u_hsc_special_cycle (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .req, .snoop_last, .intervention_code, .resp,
    .init_out_n, .smm_active_out, .smm_steer_valid, .smm_to_dram, .compat_pci_req, .compat_pci_kind,
    .compat_pci_master_abort, .compat_pci_ready);
  hsc_pci_partner u_hsc_pci_partner (.sys_clk, .dly, .compat_pci_req, .compat_pci_ready,
    .compat_pci_master_abort);

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Avalon master: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rdo);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rdo = avs_readdata;
    check("bus wait", n >= 50, 0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  // One host request; records steering, forwarded kind, abort and response
  task automatic host(input hsc_pkg::hsc_kind_t k, input logic [7:0] ty, input logic fl, input logic cf,
                      input logic mem);
    @(posedge sys_clk);
    req <= '{valid: 1'b1, kind: k, first_phase_address: addr[35:3], second_phase_type_bits: ty,
             smm_request_flag: fl, code_fetch: cf};
    snoop_last <= mem;
    @(posedge sys_clk);
    st_v = smm_steer_valid;
    st_d = smm_to_dram;
    req.valid <= 1'b0;
    snoop_last <= 1'b0;
    lat = 0;
    ab_seen = 1'b0;
    pk = 2'h0;
    do
    begin
      @(posedge sys_clk);
      lat++;
      if (compat_pci_req === 1'b1) pk = compat_pci_kind;
      ab_seen |= compat_pci_master_abort;
    end
    while (resp.valid !== 1'b1 && lat < 100);
    rc = resp.code;
    check("resp wait", lat >= 100, 0);
  endtask : host

  task automatic t_regs;
    bus(1'b0, 4'h0, 32'h0, rd);
    check("ctrl", rd, 32'h0);
    bus(1'b0, 4'h4, 32'h0, rd);
    check("base", rd, 32'h0000000a);
    bus(1'b0, 4'h8, 32'h0, rd);
    check("size", rd, 32'h00000001);
    bus(1'b0, 4'h1, 32'h0, rd);
    check("unmapped", rd, 32'hdeadbeef);
  endtask : t_regs

  // Flag held high so a quick cycle that leaks into SMM tracking shows up
  task automatic t_quick;
    logic [7:0] codes [4] = '{8'h00, 8'h02, 8'h04, 8'h05};
    addr = 36'hffffffff8;
    foreach (codes[i])
    begin
      host(hsc_pkg::TK_SPECIAL, codes[i], 1'b1, 1'b0, 1'b0);
      check("quick", {lat[7:0], rc, init_out_n, smm_active_out, compat_pci_req}, {8'd1, 5'b00100});
    end
    host(hsc_pkg::TK_BRTRACE, 8'h55, 1'b0, 1'b0, 1'b0);
    check("trace", {lat[7:0], rc}, {8'd1, 2'b00});
  endtask : t_quick

  task automatic t_shut_smi;
    int m;
    host(hsc_pkg::TK_SPECIAL, 8'h01, 1'b0, 1'b0, 1'b0);
    m = 0;
    while (init_out_n === 1'b0 && m < 20)
    begin
      m++;
      @(posedge sys_clk);
    end
    check("init len", m, 4);
    host(hsc_pkg::TK_SPECIAL, 8'h07, 1'b1, 1'b0, 1'b0);
    check("smm set", smm_active_out, 1'b1);
    host(hsc_pkg::TK_SPECIAL, 8'h00, 1'b0, 1'b0, 1'b0);
    check("smm hold", smm_active_out, 1'b1);
    host(hsc_pkg::TK_SPECIAL, 8'h07, 1'b0, 1'b0, 1'b0);
    check("smm clear", smm_active_out, 1'b0);
  endtask : t_shut_smi

  task automatic t_fwd(input logic [7:0] ty, input logic [3:0] d, input logic [1:0] kind);
    dly <= d;
    host(hsc_pkg::TK_SPECIAL, ty, 1'b0, 1'b0, 1'b0);
    check("fwd", {pk, ab_seen, rc}, {kind, 1'b1, 2'b00});
  endtask : t_fwd

  task automatic mem_case(input logic [3:0] ctl, input logic [35:0] a, input logic fl, input logic cf,
                          input logic [1:0] tp, input logic ev, input logic ed, input logic [1:0] erc);
    bus(1'b1, 4'h0, {28'h0, ctl}, rd);
    addr = a;
    intervention_code <= tp;
    repeat (2) @(posedge sys_clk);
    host(hsc_pkg::TK_MEM, 8'h00, fl, cf, 1'b1);
    check("steer", {st_v, st_d & ev}, {ev, ed});
    check("tp resp", {lat[7:0], rc}, {8'd1, erc});
  endtask : mem_case

  task automatic t_smm;
    mem_case(4'h0, WIN, 1, 1, 2'h0, 0, 0, hsc_pkg::RESP_NORMAL);
    mem_case(4'h1, WIN, 0, 0, 2'h2, 1, 0, hsc_pkg::RESP_RETRY);
    mem_case(4'h1, WIN, 1, 0, 2'h3, 1, 1, hsc_pkg::RESP_DEFER);
    mem_case(4'h5, WIN, 1, 1, 2'h0, 1, 1, hsc_pkg::RESP_NORMAL);
    mem_case(4'h5, WIN, 1, 0, 2'h0, 1, 0, hsc_pkg::RESP_NORMAL);
    mem_case(4'h5, WIN, 0, 1, 2'h0, 1, 0, hsc_pkg::RESP_NORMAL);
    mem_case(4'h3, WIN, 0, 0, 2'h0, 1, 1, hsc_pkg::RESP_NORMAL);
    mem_case(4'h3, OUTW, 0, 0, 2'h0, 0, 0, hsc_pkg::RESP_NORMAL);
    bus(1'b1, 4'h8, 32'h2, rd);
    mem_case(4'h3, OUTW, 0, 0, 2'h0, 1, 1, hsc_pkg::RESP_NORMAL);
    bus(1'b1, 4'h8, 32'h1, rd);
    bus(1'b1, 4'h4, 32'hb, rd);
    mem_case(4'h3, WIN, 0, 0, 2'h0, 0, 0, hsc_pkg::RESP_NORMAL);
    mem_case(4'h3, OUTW, 0, 0, 2'h0, 1, 1, hsc_pkg::RESP_NORMAL);
    bus(1'b1, 4'h4, 32'ha, rd);
    mem_case(4'hb, WIN, 0, 0, 2'h0, 1, 0, hsc_pkg::RESP_NORMAL);
    mem_case(4'hb, WIN, 1, 0, 2'h0, 1, 1, hsc_pkg::RESP_NORMAL);
  endtask : t_smm

  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_regs();
    $display("test registers done");
    t_quick();
    $display("test quick cycles done");
    t_shut_smi();
    $display("test shutdown and smi done");
    t_fwd(8'h03, 4'h0, hsc_pkg::PCI_SC_HALT);
    t_fwd(8'h06, 4'h6, hsc_pkg::PCI_SC_STOPGRANT);
    $display("test forwarding done");
    t_smm();
    $display("test smm steering done");
    wrap_up();
  end

  // Watchdog well past the expected run length
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    wrap_up();
  end
endmodule : hsc_special_cycle_bench
